// ==== core/ssdr_pkg.sv ====
package ssdr_pkg;

  // APB register map, byte addresses.
  localparam logic [7:0] SSDR_OFS_CTRL = 8'h00;
  localparam logic [7:0] SSDR_OFS_STAT = 8'h04;
  localparam logic [7:0] SSDR_OFS_DATA = 8'h08;

  // Control register field positions.
  localparam int SSDR_CTRL_RXIE = 7;
  localparam int SSDR_CTRL_MSTR = 5;
  localparam int SSDR_CTRL_CPOL = 4;
  localparam int SSDR_CTRL_CPHA = 3;
  localparam int SSDR_CTRL_EN   = 1;
  localparam int SSDR_CTRL_TXIE = 0;

  // Status and control register field positions.
  localparam int SSDR_STAT_RXF  = 7;
  localparam int SSDR_STAT_ERIE = 6;
  localparam int SSDR_STAT_OVR  = 5;
  localparam int SSDR_STAT_MODE_FAULT_FLAG = 4;
  localparam int SSDR_STAT_TXE  = 3;
  localparam int SSDR_STAT_MFEN = 2;
  localparam int SSDR_STAT_RATE = 0;

  // Reset values.
  localparam logic [7:0] SSDR_CTRL_RST = 8'h28;
  localparam logic [7:0] SSDR_STAT_RST = 8'h08;
  localparam logic [7:0] SSDR_DATA_RST = 8'h00;

  // Rate divisors for rate select codes 00, 01, 10 and 11.
  localparam logic [7:0] SSDR_DIV_0 = 8'h02;
  localparam logic [7:0] SSDR_DIV_1 = 8'h08;
  localparam logic [7:0] SSDR_DIV_2 = 8'h20;
  localparam logic [7:0] SSDR_DIV_3 = 8'h80;

  // Bits in a byte and serial clock edges in a master byte.
  localparam logic [2:0] SSDR_LAST_BIT  = 3'h7;
  localparam logic [3:0] SSDR_LAST_EDGE = 4'hf;

  typedef struct packed {
    logic       rx_full_irq_enable;
    logic       master_select;
    logic       cpol;
    logic       cpha;
    logic       port_enable;
    logic       tx_empty_irq_enable;
  } ssdr_ctrl_s;

  typedef struct packed {
    logic       error_irq_enable;
    logic       mode_fault_detect_enable;
    logic [1:0] rate_select;
  } ssdr_cfg_s;

  typedef enum logic {
    SSDR_IDLE = 1'b0,
    SSDR_RUN  = 1'b1
  } ssdr_state_e;

endpackage : ssdr_pkg

// ==== core/ssdr_top.sv ====
`timescale 1ns/1ps
// Behaviour
// - Enable bit runs port; clearing partially resets.
// - Transmit-empty flag interrupts when its enable set.
// - Receiver-full sets on each received byte.
// - Data read clears receiver-full flag.
// - Error enable gates overrun, mode-fault interrupts.
// - Overrun keeps old byte, drops new byte.
// - Status-then-data read clears overrun flag.
// - Mode fault: slave select misbehaves.
// - Status-then-data write clears mode fault.
// - Transmit-empty sets when buffer feeds shifter.
// - Idle port empties buffer within two cycles.
// - Busy slave loads shifter only after byte.
// - Detect enable gates mode fault setting and master slave select release.
// - Master without detection releases slave select pin.
// - Slave detection off only suppresses mode fault.
// - Rate code picks divisor 2/8/32/128.
// - Serial clock is clock over twice divisor.
// - Data writes transmit buffer, reads receive buffer.
// - Receive enable gates receiver-full interrupt.
// - Master select bit; reset selects master.
module ssdr_top
  import ssdr_pkg::*;
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata_ff,
  output logic             pready_ff,
  output logic             pslverr_ff,
  // Serial link pins.
  input  wire logic        sck_in,
  output logic             sck_out_ff,
  output logic             sck_oe_n_ff,
  input  wire logic        mosi_in,
  output logic             mosi_out_ff,
  output logic             mosi_oe_n_ff,
  input  wire logic        miso_in,
  output logic             miso_out_ff,
  output logic             miso_oe_n_ff,
  input  wire logic        ss_n_in,
  output logic             ss_gpio_release_ff,
  // Interrupt request.
  output logic             irq_ff
);

  ssdr_ctrl_s   ctrl_ff;
  ssdr_cfg_s    cfg_ff;
  ssdr_state_e  state_ff;
  ssdr_state_e  nxt_state;
  logic         rx_full_ff;
  logic         overrun_ff;
  logic         mode_fault_ff;
  logic         tx_empty_ff;
  logic         ovr_armed_ff;
  logic         mode_fault_flag_armed_ff;
  logic [7:0]   tx_buf_ff;
  logic [7:0]   rx_buf_ff;
  logic [7:0]   tx_sh_ff;
  logic [7:0]   rx_sh_ff;
  logic [2:0]   bit_cnt_ff;
  logic [3:0]   edge_cnt_ff;
  logic [7:0]   baud_cnt_ff;
  logic         sck_prev_ff;
  logic         ss_prev_ff;
  logic         sck_ff;

  logic         acc_take;
  logic         wr_ctrl;
  logic         wr_stat;
  logic         wr_data;
  logic         rd_stat;
  logic         rd_data;
  logic         mapped;
  logic         en;
  logic         master;
  logic [7:0]   divisor;
  logic         tick;
  logic         slave_edge;
  logic         edge_ev;
  logic         lead;
  logic         sample;
  logic         drive;
  logic         done;
  logic         load;
  logic         slave_start;
  logic         slave_abort;
  logic         master_end;
  logic         din;
  logic [7:0]   ctrl_rd;
  logic [7:0]   stat_rd;

  assign en     = ctrl_ff.port_enable;
  assign master = ctrl_ff.master_select;

  // The slave answers on the second access cycle, so prdata is a flop.
  assign acc_take = psel & penable & pready_ff;
  assign mapped   = (paddr == SSDR_OFS_CTRL) | (paddr == SSDR_OFS_STAT) | (paddr == SSDR_OFS_DATA);
  assign wr_ctrl  = acc_take & pwrite & (paddr == SSDR_OFS_CTRL);
  assign wr_stat  = acc_take & pwrite & (paddr == SSDR_OFS_STAT);
  assign wr_data  = acc_take & pwrite & (paddr == SSDR_OFS_DATA);
  assign rd_stat  = acc_take & ~pwrite & (paddr == SSDR_OFS_STAT);
  assign rd_data  = acc_take & ~pwrite & (paddr == SSDR_OFS_DATA);

  always_comb begin
    ctrl_rd                 = 8'h00;
    ctrl_rd[SSDR_CTRL_RXIE] = ctrl_ff.rx_full_irq_enable;
    ctrl_rd[SSDR_CTRL_MSTR] = ctrl_ff.master_select;
    ctrl_rd[SSDR_CTRL_CPOL] = ctrl_ff.cpol;
    ctrl_rd[SSDR_CTRL_CPHA] = ctrl_ff.cpha;
    ctrl_rd[SSDR_CTRL_EN]   = ctrl_ff.port_enable;
    ctrl_rd[SSDR_CTRL_TXIE] = ctrl_ff.tx_empty_irq_enable;
    stat_rd                 = 8'h00;
    stat_rd[SSDR_STAT_RXF]  = rx_full_ff;
    stat_rd[SSDR_STAT_ERIE] = cfg_ff.error_irq_enable;
    stat_rd[SSDR_STAT_OVR]  = overrun_ff;
    stat_rd[SSDR_STAT_MODE_FAULT_FLAG] = mode_fault_ff;
    stat_rd[SSDR_STAT_TXE]  = tx_empty_ff;
    stat_rd[SSDR_STAT_MFEN] = cfg_ff.mode_fault_detect_enable;
    stat_rd[SSDR_STAT_RATE+:2] = cfg_ff.rate_select;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= psel & penable & ~pready_ff;
      pslverr_ff <= psel & penable & ~pready_ff & ~mapped;
      if (psel & penable & ~pready_ff & ~pwrite) begin
        unique case (paddr)
          SSDR_OFS_CTRL: prdata_ff <= {24'h00_0000, ctrl_rd};
          SSDR_OFS_STAT: prdata_ff <= {24'h00_0000, stat_rd};
          SSDR_OFS_DATA: prdata_ff <= {24'h00_0000, rx_buf_ff};
          default:       prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control and configuration bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= '{rx_full_irq_enable: SSDR_CTRL_RST[SSDR_CTRL_RXIE],
                   master_select:      SSDR_CTRL_RST[SSDR_CTRL_MSTR],
                   cpol:               SSDR_CTRL_RST[SSDR_CTRL_CPOL],
                   cpha:               SSDR_CTRL_RST[SSDR_CTRL_CPHA],
                   port_enable:        SSDR_CTRL_RST[SSDR_CTRL_EN],
                   tx_empty_irq_enable: SSDR_CTRL_RST[SSDR_CTRL_TXIE]};
      cfg_ff  <= '{error_irq_enable:         SSDR_STAT_RST[SSDR_STAT_ERIE],
                   mode_fault_detect_enable: SSDR_STAT_RST[SSDR_STAT_MFEN],
                   rate_select:              SSDR_STAT_RST[SSDR_STAT_RATE+:2]};
    end else begin
      if (wr_ctrl) begin
        ctrl_ff.rx_full_irq_enable  <= pwdata[SSDR_CTRL_RXIE];
        ctrl_ff.master_select       <= pwdata[SSDR_CTRL_MSTR];
        ctrl_ff.cpol                <= pwdata[SSDR_CTRL_CPOL];
        ctrl_ff.cpha                <= pwdata[SSDR_CTRL_CPHA];
        ctrl_ff.port_enable         <= pwdata[SSDR_CTRL_EN];
        ctrl_ff.tx_empty_irq_enable <= pwdata[SSDR_CTRL_TXIE];
      end
      if (wr_stat) begin
        // Flag positions are ignored here.
        cfg_ff.error_irq_enable         <= pwdata[SSDR_STAT_ERIE];
        cfg_ff.mode_fault_detect_enable <= pwdata[SSDR_STAT_MFEN];
        cfg_ff.rate_select              <= pwdata[SSDR_STAT_RATE+:2];
      end
    end
  end

  // Master baud generator; one tick every divisor clocks halves the period.
  always_comb begin
    unique case (cfg_ff.rate_select)
      2'b00: divisor = SSDR_DIV_0;
      2'b01: divisor = SSDR_DIV_1;
      2'b10: divisor = SSDR_DIV_2;
      2'b11: divisor = SSDR_DIV_3;
    endcase
  end

  assign tick = master & (state_ff == SSDR_RUN) & (baud_cnt_ff == divisor - 8'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt_ff <= 8'h00;
    end else if (!en || state_ff == SSDR_IDLE || tick) begin
      baud_cnt_ff <= 8'h00;
    end else begin
      baud_cnt_ff <= baud_cnt_ff + 8'h01;
    end
  end

  // Edge classification common to master and slave.
  assign slave_edge  = en & ~master & ~ss_n_in & (sck_in ^ sck_prev_ff);
  assign edge_ev     = master ? tick : (slave_edge & ((state_ff == SSDR_RUN) | ctrl_ff.cpha));
  assign lead        = master ? (sck_ff == ctrl_ff.cpol) : (sck_prev_ff == ctrl_ff.cpol);
  assign sample      = edge_ev & (lead ^ ctrl_ff.cpha);
  assign drive       = edge_ev & ~(lead ^ ctrl_ff.cpha) & ~(ctrl_ff.cpha & (bit_cnt_ff == 3'h0));
  assign done        = sample & (bit_cnt_ff == SSDR_LAST_BIT);
  assign din         = master ? miso_in : mosi_in;
  assign slave_start = en & ~master & (state_ff == SSDR_IDLE) & ~ss_n_in
                       & (ctrl_ff.cpha ? slave_edge : ss_prev_ff);
  // A slave that loses its select mid-byte drops the byte.
  assign slave_abort = en & ~master & (state_ff == SSDR_RUN) & ss_n_in;
  assign master_end  = tick & (edge_cnt_ff == SSDR_LAST_EDGE);
  // The buffer feeds the shifter only while no byte is in flight.
  assign load        = en & (state_ff == SSDR_IDLE) & ~tx_empty_ff & ~slave_start;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SSDR_IDLE: begin
        if (en && master && load) begin
          nxt_state = SSDR_RUN;
        end else if (slave_start) begin
          nxt_state = SSDR_RUN;
        end
      end
      SSDR_RUN: begin
        if (!en || master_end || slave_abort || (!master && done)) begin
          nxt_state = SSDR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= SSDR_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_prev_ff <= 1'b0;
      ss_prev_ff  <= 1'b1;
    end else begin
      sck_prev_ff <= sck_in;
      ss_prev_ff  <= ss_n_in;
    end
  end

  // Serial clock and edge count of a master byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_ff      <= 1'b0;
      edge_cnt_ff <= 4'h0;
    end else if (!en || state_ff == SSDR_IDLE) begin
      sck_ff      <= ctrl_ff.cpol;
      edge_cnt_ff <= 4'h0;
    end else if (tick) begin
      sck_ff      <= ~sck_ff;
      edge_cnt_ff <= edge_cnt_ff + 4'h1;
    end
  end

  // Shifters.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh_ff   <= 8'h00;
      rx_sh_ff   <= 8'h00;
      bit_cnt_ff <= 3'h0;
    end else if (!en || slave_abort) begin
      bit_cnt_ff <= 3'h0;
    end else begin
      if (load) begin
        tx_sh_ff <= tx_buf_ff;
      end else if (drive) begin
        tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
      end
      if (sample) begin
        rx_sh_ff   <= {rx_sh_ff[6:0], din};
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
      end
    end
  end

  // Transmit buffer and its empty flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_ff   <= SSDR_DATA_RST;
      tx_empty_ff <= SSDR_STAT_RST[SSDR_STAT_TXE];
    end else begin
      if (wr_data) begin
        tx_buf_ff <= pwdata[7:0];
      end
      if (load || !en) begin
        tx_empty_ff <= 1'b1;
      end else if (wr_data) begin
        tx_empty_ff <= 1'b0;
      end
    end
  end

  // Receive buffer, full flag and overrun.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_ff  <= SSDR_DATA_RST;
      rx_full_ff <= 1'b0;
      overrun_ff <= 1'b0;
    end else begin
      if (done && rx_full_ff && !rd_data) begin
        overrun_ff <= 1'b1;
      end else if (rd_data && ovr_armed_ff) begin
        overrun_ff <= 1'b0;
      end
      if (done && !(rx_full_ff && !rd_data)) begin
        rx_buf_ff  <= {rx_sh_ff[6:0], din};
        rx_full_ff <= 1'b1;
      end else if (rd_data) begin
        rx_full_ff <= 1'b0;
      end
    end
  end

  // Mode fault detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_fault_ff <= 1'b0;
    end else if (cfg_ff.mode_fault_detect_enable && en
                 && ((master && !ss_n_in) || slave_abort)) begin
      mode_fault_ff <= 1'b1;
    end else if (wr_data && mode_fault_flag_armed_ff) begin
      mode_fault_ff <= 1'b0;
    end
  end

  // A status read arms the clear; it sees the flag as latched in prdata.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_armed_ff  <= 1'b0;
      mode_fault_flag_armed_ff <= 1'b0;
    end else begin
      if (rd_stat) begin
        ovr_armed_ff <= prdata_ff[SSDR_STAT_OVR];
      end else if (rd_data) begin
        ovr_armed_ff <= 1'b0;
      end
      if (rd_stat) begin
        mode_fault_flag_armed_ff <= prdata_ff[SSDR_STAT_MODE_FAULT_FLAG];
      end else if (wr_data) begin
        mode_fault_flag_armed_ff <= 1'b0;
      end
    end
  end

  // Pin drivers; enables are active low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_out_ff         <= 1'b0;
      sck_oe_n_ff        <= 1'b1;
      mosi_out_ff        <= 1'b0;
      mosi_oe_n_ff       <= 1'b1;
      miso_out_ff        <= 1'b0;
      miso_oe_n_ff       <= 1'b1;
      ss_gpio_release_ff <= 1'b1;
    end else begin
      sck_out_ff         <= sck_ff;
      sck_oe_n_ff        <= ~(en & master);
      mosi_out_ff        <= tx_sh_ff[7];
      mosi_oe_n_ff       <= ~(en & master);
      miso_out_ff        <= tx_sh_ff[7];
      miso_oe_n_ff       <= ~(en & ~master & ~ss_n_in);
      ss_gpio_release_ff <= ~en | (master & ~cfg_ff.mode_fault_detect_enable);
    end
  end

  // One level request; overrun and mode fault share the error enable, each other source has its own.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (tx_empty_ff & ctrl_ff.tx_empty_irq_enable)
              | (rx_full_ff & ctrl_ff.rx_full_irq_enable)
              | (cfg_ff.error_irq_enable & (overrun_ff | mode_fault_ff));
    end
  end

endmodule : ssdr_top

// ==== test/ssdr_checker.sv ====
`timescale 1ns/1ps
module ssdr_checker
  import ssdr_pkg::*;
(
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // APB.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata_ff,
  input wire logic        pready_ff,
  input wire logic        pslverr_ff,
  // Link and interrupt.
  input wire logic        sck_out_ff,
  input wire logic        ss_n_in,
  input wire logic        ss_gpio_release_ff,
  input wire logic        irq_ff
);
  logic [7:0] ctrl_ff;
  logic [3:0] cfg_ff;
  logic [7:0] gap_ff;
  logic       sck_d_ff;
  logic       wr_ok;
  logic [7:0] div;
  logic       mapped;
  assign wr_ok = psel && penable && pready_ff && pwrite;
  assign div = 8'h02 << {cfg_ff[1:0], 1'b0};
  assign mapped = (paddr == SSDR_OFS_CTRL) || (paddr == SSDR_OFS_STAT) || (paddr == SSDR_OFS_DATA);
  // Shadow of the written configuration, so pin rules can be judged from the bus alone.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= SSDR_CTRL_RST;
      cfg_ff  <= 4'h0;
    end else if (wr_ok && paddr == SSDR_OFS_CTRL) begin
      ctrl_ff <= pwdata[7:0];
    end else if (wr_ok && paddr == SSDR_OFS_STAT) begin
      cfg_ff <= {pwdata[6], pwdata[2:0]};
    end
  end
  // Cycles since the serial clock last moved; saturates so idle gaps never wrap.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_ff   <= 8'hff;
      sck_d_ff <= 1'b0;
    end else begin
      sck_d_ff <= sck_out_ff;
      if (sck_out_ff != sck_d_ff) begin
        gap_ff <= 8'h01;
      end else if (gap_ff != 8'hff) begin
        gap_ff <= gap_ff + 8'h01;
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_pulse_a: assert property (pready_ff |=> !pready_ff)
    else $error("ready held too long");
  pready_wait_a: assert property (psel && penable && !pready_ff |=> pready_ff)
    else $error("ready missing after wait state");
  slverr_only_a: assert property (pslverr_ff |-> pready_ff)
    else $error("error without ready");
  unmapped_err_a: assert property (psel && penable && pready_ff |-> pslverr_ff == !mapped)
    else $error("error response wrong for address");
  upper_zero_a: assert property (pready_ff && !pwrite |-> prdata_ff[31:8] == 24'h0)
    else $error("upper read bits not zero");
  sck_rate_a: assert property (ctrl_ff[SSDR_CTRL_MSTR] && $changed(sck_out_ff) |-> gap_ff >= div)
    else $error("serial clock half period too short");
  ss_release_a: assert property ($stable(ctrl_ff) && $stable(cfg_ff) |-> ss_gpio_release_ff ==
    (!ctrl_ff[SSDR_CTRL_EN] || (ctrl_ff[SSDR_CTRL_MSTR] && !cfg_ff[2])))
    else $error("select pin release wrong");
  fault_irq_a: assert property ((ctrl_ff[SSDR_CTRL_EN] && ctrl_ff[SSDR_CTRL_MSTR] && cfg_ff[3] && cfg_ff[2]
    && !ss_n_in) [*4] |=> irq_ff)
    else $error("mode fault gave no interrupt");
endmodule : ssdr_checker

bind ssdr_top ssdr_checker ssdr_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
  .pslverr_ff(pslverr_ff), .sck_out_ff(sck_out_ff), .ss_n_in(ss_n_in),
  .ss_gpio_release_ff(ss_gpio_release_ff), .irq_ff(irq_ff));

// ==== test/ssdr_far_slave.sv ====
`timescale 1ns/1ps
module ssdr_far_slave (
  // Link.
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // Bench side.
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte,
  output int              byte_count
);
  logic [7:0] sh_out;
  logic [7:0] sh_in;
  int         bit_i;
  initial begin
    miso = 1'b0;
    bit_i = 0;
    byte_count = 0;
  end
  // Leading edge drives, trailing edge samples, clock idles low.
  always @(posedge sck) begin
    if (bit_i == 0) sh_out = tx_byte;
    miso = sh_out[7];
    sh_out = sh_out << 1;
  end
  always @(negedge sck) begin
    sh_in = {sh_in[6:0], mosi};
    bit_i++;
    if (bit_i == 8) begin
      bit_i = 0;
      rx_byte = sh_in;
      byte_count++;
      // No pull on this line, so a stale bit must not look valid.
      miso = ~miso;
    end
  end
endmodule : ssdr_far_slave

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin bad_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module tb_top
  import ssdr_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, ss_n_in, er, sck_p, sck_in, mosi_in, miso_o;
  logic [7:0]  paddr, far_tx, far_rx, m_rx, fb, s_mo, s_mi;
  logic [2:0]  oe_n;
  logic [31:0] pwdata, prdata_ff, rd;
  logic [31:0] seed = 32'h5;
  logic        pready_ff, pslverr_ff, sck_out_ff, miso_w, mosi_out_ff, irq_ff, ss_gpio_release_ff;
  logic [3:0]  m_cfg;
  int          bad_count, checks_done, far_cnt, hc, half, m_rxf, m_ovr, m_mode_fault_flag, arm_o, arm_m;
  always #50 pclk = ~pclk;
  ssdr_top ssdr_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .sck_in(sck_in), .sck_out_ff(sck_out_ff), .sck_oe_n_ff(oe_n[2]), .mosi_in(mosi_in), .mosi_out_ff(mosi_out_ff),
    .mosi_oe_n_ff(oe_n[1]), .miso_in(miso_w), .miso_out_ff(miso_o), .miso_oe_n_ff(oe_n[0]), .ss_n_in(ss_n_in),
    .ss_gpio_release_ff(ss_gpio_release_ff), .irq_ff(irq_ff));
  ssdr_far_slave ssdr_far_slave_inst (.sck(sck_out_ff), .mosi(mosi_out_ff), .miso(miso_w), .tx_byte(far_tx),
    .rx_byte(far_rx), .byte_count(far_cnt));
  // Half period of the serial clock in bus cycles.
  always @(posedge pclk) begin
    hc++;
    if (sck_out_ff !== sck_p) begin
      half = hc;
      hc = 0;
      sck_p = sck_out_ff;
    end
  end
  function logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : xs
  task automatic report_and_stop();
    if (bad_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready_ff !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata_ff;
    er = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic stat();
    apb(1'b0, SSDR_OFS_STAT, 32'h0);
    `CHK("status", {m_rxf[0], m_cfg[3], m_ovr[0], m_mode_fault_flag[0], 1'b1, m_cfg[2:0]}, rd[7:0])
    arm_o = m_ovr;
    arm_m = m_mode_fault_flag;
  endtask : stat
  task automatic rdata();
    apb(1'b0, SSDR_OFS_DATA, 32'h0);
    `CHK("data", m_rx, rd[7:0])
    m_rxf = 0;
    if (arm_o) m_ovr = 0;
    arm_o = 0;
  endtask : rdata
  // Ones go to every flag position too; they must be ignored.
  task automatic setcfg(input logic [3:0] c);
    m_cfg = c;
    apb(1'b1, SSDR_OFS_STAT, {24'h0, 1'b1, c[3], 3'h7, c[2:0]});
  endtask : setcfg
  task automatic xfer();
    int n;
    logic [7:0] tx;
    tx = xs();
    fb = xs();
    far_tx <= fb;
    n = far_cnt;
    apb(1'b1, SSDR_OFS_DATA, {24'h0, tx});
    if (arm_m) m_mode_fault_flag = 0;
    arm_m = 0;
    stat();
    // A byte that never arrives is left to the watchdog.
    while (far_cnt == n) begin
      @(posedge pclk);
    end
    `CHK("far byte", tx, far_rx)
    `CHK("half period", 2 << (2 * m_cfg[1:0]), half)
    if (m_rxf) m_ovr = 1;
    else begin
      m_rxf = 1;
      m_rx = fb;
    end
  endtask : xfer
  task automatic ss_pulse();
    ss_n_in <= 1'b0;
    repeat (6) @(posedge pclk);
    ss_n_in <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : ss_pulse
  // Far master for slave mode: four bus cycles a half period, rising leading edge, select released after nb bits.
  task automatic slv_byte(input logic [7:0] mo, input int nb, output logic [7:0] mi);
    mi = 8'h00;
    ss_n_in <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK("pin enables", 3'b110, oe_n)
    for (int i = 7; i > 7 - nb; i--) begin
      mosi_in <= mo[i];
      sck_in <= 1'b1;
      repeat (4) @(posedge pclk);
      mi[i] = miso_o;
      sck_in <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    ss_n_in <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : slv_byte
  task automatic irq_is(input logic v);
    repeat (2) @(posedge pclk);
    `CHK("irq", v, irq_ff)
  endtask : irq_is
  initial begin
    repeat (30000) @(posedge pclk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, far_tx, m_rx, m_cfg, sck_in, mosi_in} = '0;
    ss_n_in = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SSDR_OFS_CTRL, 32'h0);
    `CHK("control", 8'h28, rd[7:0])
    stat();
    rdata();
    `CHK("release", 1'b1, ss_gpio_release_ff)
    irq_is(1'b0);
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("slverr", 1'b1, er)
    setcfg(4'h4);
    stat();
    apb(1'b1, SSDR_OFS_CTRL, 32'h2a);
    // Slow rates first, so each frame starts long after the last clock edge.
    for (int r = 3; r >= 0; r--) begin
      setcfg({2'b10, r[1:0]});
      xfer();
      stat();
      rdata();
    end
    `CHK("release", 1'b1, ss_gpio_release_ff)
    `CHK("pin enables", 3'b001, oe_n)
    xfer();
    xfer();
    setcfg(4'h8);
    stat();
    irq_is(1'b1);
    rdata();
    stat();
    apb(1'b1, SSDR_OFS_CTRL, 32'h2b);
    irq_is(1'b1);
    apb(1'b1, SSDR_OFS_CTRL, 32'haa);
    irq_is(1'b0);
    xfer();
    irq_is(1'b1);
    rdata();
    irq_is(1'b0);
    ss_pulse();
    stat();
    setcfg(4'hc);
    repeat (2) @(posedge pclk);
    `CHK("release", 1'b0, ss_gpio_release_ff)
    ss_pulse();
    m_mode_fault_flag = 1;
    stat();
    irq_is(1'b1);
    setcfg(4'h8);
    stat();
    xfer();
    rdata();
    // Slave mode: a cut byte without detection, a whole byte, then a cut byte with detection.
    apb(1'b1, SSDR_OFS_CTRL, 32'h0a);
    repeat (2) @(posedge pclk);
    `CHK("release", 1'b0, ss_gpio_release_ff)
    slv_byte(xs(), 3, s_mi);
    stat();
    fb = xs();
    s_mo = xs();
    apb(1'b1, SSDR_OFS_DATA, {24'h0, fb});
    slv_byte(s_mo, 8, s_mi);
    `CHK("slave out", fb, s_mi)
    m_rxf = 1;
    m_rx = s_mo;
    stat();
    rdata();
    setcfg(4'hc);
    slv_byte(xs(), 3, s_mi);
    m_mode_fault_flag = 1;
    stat();
    apb(1'b1, SSDR_OFS_CTRL, 32'h28);
    repeat (2) @(posedge pclk);
    `CHK("release", 1'b1, ss_gpio_release_ff)
    `CHK("pin enables", 3'b111, oe_n)
    stat();
    report_and_stop();
  end
endmodule : tb_top
